// ---- core/eelr_recorder.v ----
`include "eelr_map.vh"

module eelr_recorder #(
	parameter MS_CYCLES = `EELR_CLK_HZ / 1000 * `EELR_TICK_MS,
	parameter HOUR_MS = `EELR_HOUR_MS,
	parameter KEEP_HISTORY = 1
) (
	input wire clk, // Core clock, 40 MHz
	input wire sys_rst, // Async reset, high
	input wire cmdWrite, // Command register written, pulse
	input wire swReset, // Software reset seen, pulse
	input wire hwReset, // Hardware reset seen, pulse
	input wire [7:0] devCtl, // Device control register
	input wire [7:0] featCur, // Features, last write
	input wire [7:0] featPrev, // Features, write before
	input wire [7:0] scCur, // Sector count, last write
	input wire [7:0] scPrev, // Sector count, write before
	input wire [7:0] lbaLoCur, // LBA low, last write
	input wire [7:0] lbaLoPrev, // LBA low, write before
	input wire [7:0] lbaMidCur, // LBA mid, last write
	input wire [7:0] lbaMidPrev, // LBA mid, write before
	input wire [7:0] lbaHiCur, // LBA high, last write
	input wire [7:0] lbaHiPrev, // LBA high, write before
	input wire [7:0] devHead, // Device/head register
	input wire [7:0] cmdCode, // Command code written
	input wire [7:0] devState, // Vendor nibble and state code
	input wire errLog, // Log an error for newest event, pulse
	input wire [7:0] cplError, // Error register after completion
	input wire [7:0] cplScLo, // Sector count, HOB clear
	input wire [7:0] cplScHi, // Sector count, HOB set
	input wire [7:0] cplLbaLoLo, // LBA low, HOB clear
	input wire [7:0] cplLbaLoHi, // LBA low, HOB set
	input wire [7:0] cplLbaMidLo, // LBA mid, HOB clear
	input wire [7:0] cplLbaMidHi, // LBA mid, HOB set
	input wire [7:0] cplLbaHiLo, // LBA high, HOB clear
	input wire [7:0] cplLbaHiHi, // LBA high, HOB set
	input wire [7:0] cplDevHead, // Device/head after completion
	input wire [7:0] cplStatus, // Status after completion
	input wire [151:0] cplExtInfo, // Extended error info, byte 12 low
	output wire errReady, // Error strobe will be taken
	input wire rdReq, // Log byte read request
	output wire rdReady, // Read request will be taken
	input wire [5:0] rdSector, // Log sector to read
	input wire [8:0] rdByte, // Byte within sector
	output reg [7:0] rdData, // Read byte, registered
	output reg rdValid, // Read byte valid, pulse
	output wire [7:0] errIndex, // Newest entry index
	output wire [15:0] errCount, // Device error count
	output wire logBusy // Entry write in progress
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_RDOLD = 2'h1;
	localparam [1:0] ST_WRNEW = 2'h2;
	localparam [1:0] ST_FIN = 2'h3;

	reg [1:0] state_q;
	reg [31:0] msDiv_q;
	reg [31:0] msCount_q;
	reg [31:0] hourMs_q;
	reg [15:0] hours_q;
	reg [719:0] hist_q;
	reg [2:0] histCnt_q;
	reg [7:0] state8_q;
	reg [991:0] entry_q;
	reg [7:0] slot_q;
	reg [7:0] nextSlot_q;
	reg [6:0] k_q;
	reg [7:0] index_q;
	reg [15:0] count_q;
	reg [255:0] written_q;
	reg [7:0] sum_q [0:`EELR_SECTORS-1];
	reg rdPend_q;
	reg rdIsEntry_q;
	reg rdWritten_q;
	reg [7:0] rdConst_q;
	integer i;

	wire msTick;
	wire [143:0] cmdSnap;
	wire [143:0] hwSnap;
	wire [719:0] histMasked;
	wire [271:0] errStruct;
	wire errTake;
	wire rdTake;
	wire [9:0] rdDec;
	wire [7:0] rdSlot;
	wire [14:0] hostAddr;
	wire [14:0] ramAddr;
	wire ramWe;
	wire [7:0] ramRd;
	wire [7:0] curByte;
	wire [7:0] oldByte;
	wire [7:0] hdrSum;
	wire [7:0] ckByte;
	reg [7:0] constVal;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Byte address of an entry slot: slot * 124
	function [14:0] entryBase;
		input [7:0] s;
		begin
			entryBase = {s, 7'h00} - {5'h00, s, 2'h0};
		end
	endfunction

	// Sector byte to {hit, entry number, offset in entry}
	function [9:0] entryOf;
		input [8:0] b;
		reg [8:0] d;
		begin
			d = 9'h000;
			entryOf = 10'h000;
			if (b >= `EELR_OFS_ENTRY0 && b < `EELR_OFS_ENTRY1) begin
				d = b - `EELR_OFS_ENTRY0;
				entryOf = {3'b100, d[6:0]};
			end else if (b >= `EELR_OFS_ENTRY1 && b < `EELR_OFS_ENTRY2) begin
				d = b - `EELR_OFS_ENTRY1;
				entryOf = {3'b101, d[6:0]};
			end else if (b >= `EELR_OFS_ENTRY2 && b < `EELR_OFS_ENTRY3) begin
				d = b - `EELR_OFS_ENTRY2;
				entryOf = {3'b110, d[6:0]};
			end else if (b >= `EELR_OFS_ENTRY3 && b < `EELR_OFS_COUNT_LO) begin
				d = b - `EELR_OFS_ENTRY3;
				entryOf = {3'b111, d[6:0]};
			end
		end
	endfunction

	// Reserved low-nibble codes fall back to unknown
	function [7:0] stateCode;
		input [7:0] s;
		begin
			if (s[3:0] > `EELR_ST_OFFLINE) begin
				stateCode = {s[7:4], `EELR_ST_UNKNOWN};
			end else begin
				stateCode = s;
			end
		end
	endfunction

	// ----------------------------------------
	// Power-on timers
	// ----------------------------------------
	assign msTick = (msDiv_q == MS_CYCLES - 1);

	// Millisecond stamp wraps freely; hours count completed hours
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			msDiv_q <= 32'h0000_0000;
			msCount_q <= 32'h0000_0000;
			hourMs_q <= 32'h0000_0000;
			hours_q <= 16'h0000;
		end else begin
			msDiv_q <= msTick ? 32'h0000_0000 : msDiv_q + 32'h0000_0001;
			if (msTick) begin
				msCount_q <= msCount_q + 32'h0000_0001;
				if (hourMs_q == HOUR_MS - 1) begin
					hourMs_q <= 32'h0000_0000;
					hours_q <= hours_q + 16'h0001;
				end else begin
					hourMs_q <= hourMs_q + 32'h0000_0001;
				end
			end
		end
	end

	// ----------------------------------------
	// Command and reset history
	// ----------------------------------------
	// Task-file image as it stood when the command register was written
	assign cmdSnap = {msCount_q, 8'h00, cmdCode, devHead, lbaHiPrev, lbaHiCur,
		lbaMidPrev, lbaMidCur, lbaLoPrev, lbaLoCur, scPrev, scCur,
		featPrev, featCur, devCtl};
	// Vendor part of a hardware reset snapshot is left zero
	assign hwSnap = {msCount_q, 104'h0, `EELR_HW_RESET_MARK};

	// Newest snapshot enters at the top; the oldest drops out
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hist_q <= 720'h0;
			histCnt_q <= 3'h0;
			state8_q <= 8'h00;
		end else if (hwReset || cmdWrite || swReset) begin
			hist_q <= {hwReset ? hwSnap : cmdSnap, hist_q[719:144]};
			histCnt_q <= (histCnt_q == 3'h5) ? histCnt_q : histCnt_q + 3'h1;
			state8_q <= stateCode(devState);
		end
	end

	// Slots without a real predecessor read as zero
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : gSnap
			localparam integer NEED = 5 - g;
			wire keep;
			assign keep = (g == 4) || (KEEP_HISTORY != 0);
			assign histMasked[g*144 +: 144] =
				(keep && histCnt_q >= NEED) ? hist_q[g*144 +: 144] : 144'h0;
		end
	endgenerate

	// Error description; reset-specific bytes come from the caller
	assign errStruct = {hours_q, state8_q, cplExtInfo, cplStatus, cplDevHead,
		cplLbaHiHi, cplLbaHiLo, cplLbaMidHi, cplLbaMidLo,
		cplLbaLoHi, cplLbaLoLo, cplScHi, cplScLo,
		cplError, 8'h00};

	// ----------------------------------------
	// Entry writer
	// ----------------------------------------
	assign errReady = (state_q == ST_IDLE);
	assign errTake = errLog && errReady;
	assign logBusy = (state_q != ST_IDLE);
	assign curByte = entry_q[{k_q, 3'b000} +: 8];
	assign oldByte = written_q[slot_q] ? ramRd : 8'h00;
	assign ramWe = (state_q == ST_WRNEW);
	assign ramAddr = (state_q == ST_IDLE) ? hostAddr : entryBase(slot_q) + {8'h00, k_q};

	// Each byte is read then rewritten so the sector sum tracks the change
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			entry_q <= 992'h0;
			slot_q <= 8'h00;
			nextSlot_q <= 8'h00;
			k_q <= 7'h00;
			index_q <= 8'h00;
			count_q <= 16'h0000;
			written_q <= 256'h0;
			for (i = 0; i < `EELR_SECTORS; i = i + 1) begin
				sum_q[i] <= 8'h00;
			end
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (errTake) begin
						entry_q <= {errStruct, histMasked};
						slot_q <= nextSlot_q;
						k_q <= 7'h00;
						state_q <= ST_RDOLD;
					end
				end
				ST_RDOLD: begin
					state_q <= ST_WRNEW;
				end
				ST_WRNEW: begin
					sum_q[slot_q[7:2]] <= sum_q[slot_q[7:2]] + curByte - oldByte;
					if (k_q == `EELR_ENTRY_LAST) begin
						state_q <= ST_FIN;
					end else begin
						k_q <= k_q + 7'h01;
						state_q <= ST_RDOLD;
					end
				end
				ST_FIN: begin
					index_q <= slot_q;
					written_q[slot_q] <= 1'b1;
					nextSlot_q <= slot_q + 8'h01;
					if (count_q != `EELR_COUNT_MAX) begin
						count_q <= count_q + 16'h0001;
					end
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// 8-bit index cannot leave the legal range
	assign errIndex = index_q;
	assign errCount = count_q;

	// ----------------------------------------
	// Host read path
	// ----------------------------------------
	// Reads wait out an entry write; errors take priority in the same cycle
	assign rdReady = (state_q == ST_IDLE) && !errLog && !rdPend_q;
	assign rdTake = rdReq && rdReady;
	assign rdDec = entryOf(rdByte);
	assign rdSlot = {rdSector, rdDec[8:7]};
	assign hostAddr = entryBase(rdSlot) + {8'h00, rdDec[6:0]};
	assign hdrSum = `EELR_LOG_VERSION + index_q + count_q[7:0] + count_q[15:8];
	assign ckByte = 8'h00 - (sum_q[rdSector] + ((rdSector == 6'h00) ? hdrSum : 8'h00));

	// Header fields live only in sector zero
	always @* begin
		constVal = 8'h00;
		if (rdByte == `EELR_OFS_CHECKSUM) begin
			constVal = ckByte;
		end else if (rdSector == 6'h00) begin
			case (rdByte)
				`EELR_OFS_VERSION: constVal = `EELR_LOG_VERSION;
				`EELR_OFS_INDEX_LO: constVal = index_q;
				`EELR_OFS_INDEX_HI: constVal = 8'h00;
				`EELR_OFS_COUNT_LO: constVal = count_q[7:0];
				`EELR_OFS_COUNT_HI: constVal = count_q[15:8];
				default: constVal = 8'h00;
			endcase
		end
	end

	// Two-stage answer: decode with the RAM read, then select
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdPend_q <= 1'b0;
			rdIsEntry_q <= 1'b0;
			rdWritten_q <= 1'b0;
			rdConst_q <= 8'h00;
			rdData <= 8'h00;
			rdValid <= 1'b0;
		end else begin
			rdPend_q <= rdTake;
			rdValid <= rdPend_q;
			if (rdTake) begin
				rdIsEntry_q <= rdDec[9];
				rdWritten_q <= written_q[rdSlot];
				rdConst_q <= constVal;
			end
			if (rdPend_q) begin
				if (rdIsEntry_q) begin
					rdData <= rdWritten_q ? ramRd : 8'h00;
				end else begin
					rdData <= rdConst_q;
				end
			end
		end
	end

	// ----------------------------------------
	// Entry store
	// ----------------------------------------
	eelr_byte_ram #(
		.AW(15),
		.DEPTH(`EELR_STORE_DEPTH)
	) uStore (
		.clk(clk),
		.sys_rst(sys_rst),
		.addr(ramAddr),
		.wrEn(ramWe),
		.wrData(curByte),
		.rdData(ramRd)
	);

endmodule // eelr_recorder

// ---- core/eelr_map.vh ----
`ifndef EELR_MAP_VH
`define EELR_MAP_VH

// ----------------------------------------
// Log layout
// ----------------------------------------
`define EELR_LOG_VERSION 8'h01
`define EELR_SECTORS 64
`define EELR_STORE_DEPTH 31744
`define EELR_ENTRY_LAST 7'h7b
`define EELR_OFS_VERSION 9'h000
`define EELR_OFS_INDEX_LO 9'h002
`define EELR_OFS_INDEX_HI 9'h003
`define EELR_OFS_ENTRY0 9'h004
`define EELR_OFS_ENTRY1 9'h080
`define EELR_OFS_ENTRY2 9'h0fc
`define EELR_OFS_ENTRY3 9'h178
`define EELR_OFS_COUNT_LO 9'h1f4
`define EELR_OFS_COUNT_HI 9'h1f5
`define EELR_OFS_CHECKSUM 9'h1ff

// ----------------------------------------
// Field values
// ----------------------------------------
`define EELR_HW_RESET_MARK 8'hff
`define EELR_ST_UNKNOWN 4'h0
`define EELR_ST_SLEEP 4'h1
`define EELR_ST_STANDBY 4'h2
`define EELR_ST_ACTIVE 4'h3
`define EELR_ST_OFFLINE 4'h4
`define EELR_COUNT_MAX 16'hffff

// ----------------------------------------
// Timing
// ----------------------------------------
`define EELR_CLK_HZ 40000000
`define EELR_TICK_MS 1
`define EELR_HOUR_MS 3600000

`endif

// ---- core/eelr_byte_ram.v ----
// ----------------------------------------
// Byte store for log entries
// ----------------------------------------
module eelr_byte_ram #(
	parameter AW = 15,
	parameter DEPTH = 31744
) (
	input wire clk, // Core clock
	input wire sys_rst, // Async reset, high
	input wire [AW-1:0] addr, // Byte address
	input wire wrEn, // Write strobe
	input wire [7:0] wrData, // Byte to store
	output reg [7:0] rdData // Registered read byte
);

	reg [7:0] store [0:DEPTH-1];

	// Array has no reset so it can map onto block RAM
	always @(posedge clk) begin
		if (wrEn) begin
			store[addr] <= wrData;
		end
	end

	// Read-before-write: old byte appears one cycle after the address
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdData <= 8'h00;
		end else begin
			rdData <= store[addr];
		end
	end

endmodule // eelr_byte_ram

// ---- dv/eelr_checker.sv ----
module eelr_checker (
	input wire clk, // Core clock
	input wire sys_rst, // Async reset, high
	input wire errLog, // Error strobe
	input wire errReady, // Error strobe taken
	input wire rdReq, // Read request
	input wire rdReady, // Read taken
	input wire rdValid, // Read byte valid
	input wire [7:0] errIndex, // Newest entry
	input wire [15:0] errCount, // Error count
	input wire logBusy // Entry write running
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// ------
	// Expected index and count
	// ------
	wire take = errLog && errReady;
	reg anyLog_q;
	reg [7:0] expIdx_q;
	reg [15:0] expCnt_q;
	// Latched at the take, since the outputs only move 250 cycles later
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			anyLog_q <= 1'b0;
			expIdx_q <= 8'h00;
			expCnt_q <= 16'h0000;
		end else if (take) begin
			anyLog_q <= 1'b1;
			expIdx_q <= anyLog_q ? errIndex + 8'h01 : 8'h00;
			expCnt_q <= (errCount == 16'hffff) ? errCount : errCount + 16'h0001;
		end
	end
	sequence s_take;
		errLog && errReady;
	endsequence
	sequence s_fill;
		logBusy[*8];
	endsequence
	property p_start;
		s_take |=> logBusy && !errReady;
	endproperty
	a_start: assert property (p_start) else $error("no busy after take");
	property p_busy;
		s_take |=> s_fill ##241 logBusy ##1 !logBusy;
	endproperty
	a_busy: assert property (p_busy) else $error("entry write length wrong");
	property p_idx;
		s_take |-> ##250 errIndex == expIdx_q;
	endproperty
	a_idx: assert property (p_idx) else $error("index wrong");
	property p_cnt;
		s_take |-> ##250 errCount == expCnt_q;
	endproperty
	a_cnt: assert property (p_cnt) else $error("count wrong");
	property p_empty;
		!anyLog_q |-> errIndex == 8'h00;
	endproperty
	a_empty: assert property (p_empty) else $error("index not zero");
	property p_rd;
		rdReq && rdReady |-> ##2 rdValid;
	endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
	property p_lock;
		logBusy |-> !errReady && !rdReady;
	endproperty
	a_lock: assert property (p_lock) else $error("ready while busy");
	property p_cntMove;
		$changed(errCount) |-> $past(logBusy);
	endproperty
	a_cntMove: assert property (p_cntMove) else $error("count moved idle");
endmodule // eelr_checker

bind eelr_recorder eelr_checker u_chk (.clk, .sys_rst, .errLog, .errReady, .rdReq,
	.rdReady, .rdValid, .errIndex, .errCount, .logBusy);

// ---- dv/eelr_host_model.sv ----
module eelr_host_model (
	input logic clk, // Core clock
	input logic rdReady, // Read will be taken
	output logic rdReq, // Read request
	output logic [5:0] rdSector, // Sector to read
	output logic [8:0] rdByte // Byte in sector
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------
	// Host read port
	// ------
	initial begin
		rdReq = 1'b0;
		rdSector = 6'h00;
		rdByte = 9'h000;
	end
	// Request held until taken; released lines show the inverse, not the last value
	task rd(input logic [5:0] s, input logic [8:0] b, output bit ok);
		int n;
		@(posedge clk);
		rdReq <= 1'b1;
		rdSector <= s;
		rdByte <= b;
		n = 0;
		@(negedge clk);
		while (rdReady !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		ok = n < 50;
		rdReq <= 1'b0;
		rdSector <= ~s;
		rdByte <= ~b;
	endtask
endmodule // eelr_host_model

// ---- dv/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, sys_rst, cmdWrite, swReset, hwReset, errLog, errReady, rdReq, rdReady, rdValid;
	logic logBusy;
	logic [7:0] devCtl, featCur, featPrev, scCur, scPrev, lbaLoCur, lbaLoPrev, lbaMidCur;
	logic [7:0] lbaMidPrev, lbaHiCur, lbaHiPrev, devHead, cmdCode, devState, cplError;
	logic [7:0] cplScLo, cplScHi, cplLbaLoLo, cplLbaLoHi, cplLbaMidLo, cplLbaMidHi;
	logic [7:0] cplLbaHiLo, cplLbaHiHi, cplDevHead, cplStatus, rdData, errIndex, idx, st, sum;
	logic [151:0] cplExtInfo;
	logic [5:0] rdSector;
	logic [8:0] rdByte, e9;
	logic [15:0] errCount, cnt;
	logic [31:0] lf;
	logic [111:0] hist[$];
	logic [8:0] q[$];
	logic [991:0] ent[256];
	int n_errors, checks;
	bit ok;
	// ------
	// Design and host
	// ------
	eelr_recorder #(.MS_CYCLES(4), .HOUR_MS(5)) dut (.clk, .sys_rst, .cmdWrite, .swReset,
		.hwReset, .devCtl, .featCur, .featPrev, .scCur, .scPrev, .lbaLoCur, .lbaLoPrev,
		.lbaMidCur, .lbaMidPrev, .lbaHiCur, .lbaHiPrev, .devHead, .cmdCode, .devState, .errLog,
		.cplError, .cplScLo, .cplScHi, .cplLbaLoLo, .cplLbaLoHi, .cplLbaMidLo, .cplLbaMidHi,
		.cplLbaHiLo, .cplLbaHiHi, .cplDevHead, .cplStatus, .cplExtInfo, .errReady, .rdReq,
		.rdReady, .rdSector, .rdByte, .rdData, .rdValid, .errIndex, .errCount, .logBusy);
	eelr_host_model host (.clk, .rdReady, .rdReq, .rdSector, .rdByte);
	function automatic logic [31:0] rnd();
		for (int i = 0; i < 32; i++)
			lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction
	// Timestamp and hour bytes are not predicted
	function automatic bit dc(int of);
		return of < 90 ? of % 18 >= 14 : of >= 122;
	endfunction
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task summarize();
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task fail();
		n_errors++;
		summarize();
	endtask
	task setTf(input logic [103:0] v);
		{cmdCode, devHead, lbaHiPrev, lbaHiCur, lbaMidPrev, lbaMidCur, lbaLoPrev, lbaLoCur,
			scPrev, scCur, featPrev, featCur, devCtl} <= v;
	endtask
	task setCpl(input logic [239:0] w);
		{cplExtInfo, cplStatus, cplDevHead, cplLbaHiHi, cplLbaHiLo, cplLbaMidHi, cplLbaMidLo,
			cplLbaLoHi, cplLbaLoLo, cplScHi, cplScLo, cplError} <= w;
	endtask
	// One command (0), software reset (1) or hardware reset (2)
	task ev(input int k);
		logic [127:0] v;
		logic [7:0] s;
		v = {rnd(), rnd(), rnd(), rnd()};
		s = v[119:112];
		@(posedge clk);
		setTf(v[103:0]);
		devState <= s;
		cmdWrite <= k == 0;
		swReset <= k == 1;
		hwReset <= k == 2;
		v[111:104] = 8'h00;
		if (k == 2)
			v = 128'h0ff;
		hist.push_back(v[111:0]);
		st = {s[7:4], s[3:0] > 4'h4 ? 4'h0 : s[3:0]};
		@(posedge clk);
		{cmdWrite, swReset, hwReset} <= 3'b000;
	endtask
	// Log an error, strobe once more while busy (that strobe is dropped), and note the entry image
	task err();
		logic [255:0] w;
		logic [991:0] e;
		int n;
		for (int i = 0; i < 8; i++)
			w[32*i+:32] = rnd();
		w[7:0] = 8'h00;
		w[255:248] = st;
		n = hist.size();
		for (int i = 0; i < 5; i++)
			e[144*i+:144] = (n + i >= 5) ? {32'h0, hist[n-5+i]} : 144'h0;
		e[991:720] = {16'h0000, w};
		@(posedge clk);
		setCpl(w[247:8]);
		errLog <= 1'b1;
		@(posedge clk);
		errLog <= 1'b0;
		@(posedge clk);
		errLog <= 1'b1;
		@(posedge clk);
		errLog <= 1'b0;
		for (n = 0; n < 300 && errReady !== 1'b1; n++)
			@(negedge clk);
		if (n == 300)
			fail();
		if (cnt != 16'h0000)
			idx = idx + 8'h01;
		ent[idx] = e;
		cnt = cnt + 16'h0001;
		chk({8'h00, errIndex}, {8'h00, idx});
		chk(errCount, cnt);
	endtask
	// Read a whole sector and prove its byte sum
	task sweep(input int s);
		int sl, of;
		logic [8:0] e;
		sum = 8'h00;
		for (int b = 0; b < 512; b++) begin
			sl = s * 4 + (b - 4) / 124;
			of = (b - 4) % 124;
			if (b >= 4 && b < 500)
				e = {dc(of), ent[sl][8*of+:8]};
			else if (s == 0 && b < 4)
				e = {1'b0, b == 0 ? 8'h01 : b == 2 ? idx : 8'h00};
			else if (s == 0 && b >= 500 && b < 502)
				e = {1'b0, b == 500 ? cnt[7:0] : cnt[15:8]};
			else
				e = {b == 511, 8'h00};
			q.push_back(e);
			host.rd(s[5:0], b[8:0], ok);
			if (!ok)
				fail();
		end
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk({8'h00, sum}, 16'h0000);
	endtask
	// Pair each returned byte with the oldest note
	always @(posedge clk) begin
		if (rdValid === 1'b1) begin
			if (q.size() == 0)
				chk(16'h0001, 16'h0000);
			else begin
				e9 = q.pop_front();
				sum = sum + rdData;
				if (!e9[8])
					chk({8'h00, rdData}, {8'h00, e9[7:0]});
			end
		end
	end
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Main sequence: short history, full history, then wrap of the whole log
	initial begin
		lf = 32'ha5d0;
		n_errors = 0;
		checks = 0;
		idx = 8'h00;
		cnt = 16'h0000;
		foreach (ent[i])
			ent[i] = '0;
		sys_rst = 1'b1;
		{cmdWrite, swReset, hwReset, errLog, devState} <= 12'h000;
		setTf(104'h0);
		setCpl(240'h0);
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk({8'h00, errIndex}, 16'h0000);
		ev(1);
		ev(0);
		ev(0);
		err();
		ev(2);
		ev(0);
		ev(1);
		ev(0);
		ev(0);
		err();
		sweep(63);
		sweep(0);
		for (int i = 0; i < 255; i++) begin
			ev(i % 3);
			err();
		end
		sweep(0);
		summarize();
	end
endmodule // tb_top
